// ==== include/usbi_map.svh ====
// register map, field positions, reset values and timing figures of the
// usb status interrupt block; assumes a 32-bit classic wishbone slave
`ifndef USBI_MAP_SVH
`define USBI_MAP_SVH

// byte offsets of the registers (word aligned)
`define USBI_OFS_FLAGS      4'h0
`define USBI_OFS_ENABLES    4'h4
`define USBI_OFS_CTRL       4'h8

// event flag and enable bit positions
`define USBI_BIT_SOF        6
`define USBI_BIT_STALL      5
`define USBI_BIT_IDLE       4
`define USBI_BIT_TRN        3
`define USBI_BIT_ACT        2
`define USBI_BIT_ERR        1
`define USBI_BIT_RST        0

// control register bit positions
`define USBI_CTRL_SUSPEND   0
`define USBI_CTRL_PLL_SEL   1
`define USBI_CTRL_READY     2
`define USBI_CTRL_ARMED     3

// bits that software may write in the flag register (error summary not)
`define USBI_FLAGS_WMASK    7'h7d
`define USBI_CTRL_WMASK     8'h03
`define USBI_RESET_BYTE     8'h00
`define USBI_RESET_WORD     32'h0000_0000

// idle detection time and clock rate
`define USBI_IDLE_TIME_US   3000
`define USBI_CLK_MHZ        25
// cycles the activity state needs after wake-up before a clear holds
`define USBI_WAKE_SYNC_CYC  4

`endif

// ==== include/usbi_pkg.sv ====
// types shared by the usb status interrupt block
// assumes usbi_map.svh supplies all numeric constants
package usbi_pkg;

  // register selected by a bus address
  typedef enum logic [1:0] {
    USBI_SEL_FLAGS   = 2'b00,
    USBI_SEL_ENABLES = 2'b01,
    USBI_SEL_CTRL    = 2'b10,
    USBI_SEL_NONE    = 2'b11
  } usbi_sel_type;

  // bus activity detector: armed until it fires, re-armed by idle
  typedef enum logic [0:0] {
    USBI_ACT_ARMED = 1'b0,
    USBI_ACT_FIRED = 1'b1
  } usbi_act_type;

endpackage

// ==== hw/usbi_idle_timer.sv ====
// idle detector: one pulse once the line has stayed idle long enough
// assumes line_idle is already synchronised to clk
`timescale 1ns/1ps
`default_nettype none

module usbi_idle_timer #(
  parameter int unsigned IDLE_CYCLES = 75000,
  parameter int unsigned CNT_W       = 17
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // line state
  input  wire logic line_idle,
  // one-cycle pulse when idle time is reached
  output var  logic idle_pulse
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(IDLE_CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic             done_reg;

  // count idle cycles; any activity restarts the wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (!line_idle) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (!done_reg) begin
      if (cnt_reg == LAST) begin
        done_reg <= 1'b1;  // pulse once per idle stretch
      end else begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
    end
  end

  // pulse in the cycle the count completes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_pulse <= 1'b0;
    end else begin
      idle_pulse <= line_idle && !done_reg && (cnt_reg == LAST);
    end
  end

endmodule

`default_nettype wire

// ==== hw/usbi_top.sv ====
// usb status interrupt logic: event flags, enables, combined request,
// bus activity wake-up handling, classic wishbone register slave
// assumes single-cycle event strobes from the serial interface engine on
// core_clk; d+/d- and pll lock arrive asynchronously and are synchronised
//
// Notes on behaviour
// R1 - all flags, each and-ed with its enable, or-ed into one request
// R2 - engine-set flag stays until software writes zero; writing one keeps
// R3 - software writing one to a writable flag sets it like an event
// R4 - flag register: bit 7 reads zero, bits 6..0 flags, reset zero
// R5 - stall sent event sets the stall flag
// R6 - bus idle continuously for 3 ms sets the idle flag
// R7 - transaction complete sets its flag; status read elsewhere
// R8 - clearing transaction flag advances status fifo, token transfers only
// R9 - activity on d+ or d- sets the activity flag
// R10 - error summary set only by enabled error conditions
// R11 - error summary is read-only, follows enabled error sources alone
// R12 - valid bus reset sets reset flag and clears device address
// R13 - activity clear ignored while suspended and shortly after wake-up
// R14 - on pll clock, block waits for pll lock after suspend cleared
// R15 - firmware clears suspend, then clears activity until it reads zero
// R16 - activity flag raised once per resume, not again under traffic
// R17 - activity detection re-armed only by a new idle condition
// R18 - firmware unmasks activity only after idle, may suspend on idle
// R19 - each enable gates only its own flag into the request
// R20 - flags set regardless of enables, so polling works
// R21 - enable register: bit 7 reads zero, bits 6..0 enables, reset zero
// R22 - error summary is or of enabled individual error flags
// R23 - all sources funnel into one request line
// R24 - hardware set beats software clear in the same cycle
// R25 - received start-of-frame token sets the frame flag
//
// The implementer's own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

`include "usbi_map.svh"

module usbi_top #(
  parameter int unsigned IDLE_CYCLES = `USBI_IDLE_TIME_US * `USBI_CLK_MHZ,
  parameter int unsigned IDLE_CNT_W  = 17,
  parameter int unsigned WAKE_SYNC   = `USBI_WAKE_SYNC_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // serial interface engine events, one-cycle strobes on core_clk
  input  wire logic        sof_evt,
  input  wire logic        stall_evt,
  input  wire logic        trn_evt,
  input  wire logic        bus_reset_evt,
  input  wire logic        trn_is_token,
  // error flag and error enable registers, held outside this block
  input  wire logic [7:0]  err_flags,
  input  wire logic [7:0]  err_enables,
  // bus lines and pll lock, asynchronous
  input  wire logic        usb_dp,
  input  wire logic        usb_dm,
  input  wire logic        pll_locked,
  // outputs toward processor and engine
  output var  logic        peripheral_irq_request,
  output var  logic        suspend_request,
  output var  logic        module_ready,
  output var  logic        stat_fifo_advance,
  output var  logic        dev_addr_clear
);

  // reset release through two flip-flops
  logic rst_meta_reg;
  logic rst_n;

  // asynchronous assertion, synchronous release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // pin synchronisers; only the second stage is used downstream
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= 3'h1;  // idle j state: d+ high, d- low
      pin_sync_reg <= 3'h1;
    end else begin
      pin_meta_reg <= {pll_locked, usb_dm, usb_dp};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  logic dp_s;
  logic dm_s;
  logic lock_s;
  logic line_idle;
  logic line_active;

  assign dp_s        = pin_sync_reg[0];
  assign dm_s        = pin_sync_reg[1];
  assign lock_s      = pin_sync_reg[2];
  // any state other than j counts as traffic
  assign line_idle   = dp_s && !dm_s;
  assign line_active = !line_idle;  // R9

  // functions shared by the decode and the flag update
  // map a byte address onto a register
  function automatic usbi_pkg::usbi_sel_type sel_of(input logic [3:0] a);
    unique case (a)
      `USBI_OFS_FLAGS:   sel_of = usbi_pkg::USBI_SEL_FLAGS;
      `USBI_OFS_ENABLES: sel_of = usbi_pkg::USBI_SEL_ENABLES;
      `USBI_OFS_CTRL:    sel_of = usbi_pkg::USBI_SEL_CTRL;
      default:           sel_of = usbi_pkg::USBI_SEL_NONE;
    endcase
  endfunction

  // write-then-set merge: an event in the clearing cycle survives
  function automatic logic [6:0] merge(input logic [6:0] cur,
                                       input logic       wr,
                                       input logic [6:0] wval,
                                       input logic [6:0] wmask,
                                       input logic [6:0] set);
    logic [6:0] v;
    v = wr ? ((cur & ~wmask) | (wval & wmask)) : cur;
    merge = v | set;  // R24
  endfunction

  // registers
  logic [6:0]   flags_reg;
  logic [6:0]   flags_next;
  logic [6:0]   enables_reg;
  logic         pll_sel_reg;
  logic         err_sum_reg;
  logic [15:0]  wake_cnt_reg;
  usbi_pkg::usbi_act_type act_reg;

  // bus decode; the access takes effect on the edge that raises ack
  usbi_pkg::usbi_sel_type sel;
  logic                   access;
  logic                   wr_lane0;
  logic                   wr_flags;
  logic                   wr_enables;
  logic                   wr_ctrl;

  assign sel        = sel_of(wb_adr_i);
  assign access     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane0   = access && wb_we_i && wb_sel_i[0];
  assign wr_flags   = wr_lane0 && (sel == usbi_pkg::USBI_SEL_FLAGS);
  assign wr_enables = wr_lane0 && (sel == usbi_pkg::USBI_SEL_ENABLES);
  assign wr_ctrl    = wr_lane0 && (sel == usbi_pkg::USBI_SEL_CTRL);

  // ack one cycle after the request, dropped in the following cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= access;
    end
  end

  // operating state: suspend, pll selection, wake-up settle time
  logic operational;
  logic act_clear_blocked;

  // with the pll selected the block stays idle until lock is seen
  assign operational = !suspend_request && (!pll_sel_reg || lock_s);  // R14

  // control register bits written by software
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend_request <= 1'b0;
      pll_sel_reg     <= 1'b0;
    end else if (wr_ctrl) begin
      suspend_request <= wb_dat_i[`USBI_CTRL_SUSPEND];
      pll_sel_reg     <= wb_dat_i[`USBI_CTRL_PLL_SEL];
    end
  end

  // settle counter reloads while not operational, runs down afterwards
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt_reg <= 16'h0000;
    end else if (!operational) begin
      wake_cnt_reg <= 16'(WAKE_SYNC);
    end else if (wake_cnt_reg != 16'h0000) begin
      wake_cnt_reg <= wake_cnt_reg - 16'h0001;
    end
  end

  // a clear of the activity flag is dropped until the state settles
  assign act_clear_blocked = !operational || (wake_cnt_reg != 16'h0000); // R13

  // readiness seen by firmware and by the engine
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      module_ready <= 1'b0;
    end else begin
      module_ready <= operational && !act_clear_blocked;
    end
  end

  // idle detection over the settled line state
  logic idle_pulse;

  usbi_idle_timer #(
    .IDLE_CYCLES (IDLE_CYCLES),
    .CNT_W       (IDLE_CNT_W)
  ) u_idle (
    .clk        (core_clk),
    .rst_n      (rst_n),
    .line_idle  (line_idle),
    .idle_pulse (idle_pulse)  // R6
  );

  // activity detector: fires once, re-armed only by a fresh idle
  logic act_fire;

  assign act_fire = (act_reg == usbi_pkg::USBI_ACT_ARMED) && line_active;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_reg <= usbi_pkg::USBI_ACT_ARMED;
    end else begin
      unique case (act_reg)
        usbi_pkg::USBI_ACT_ARMED: begin
          if (line_active) begin
            act_reg <= usbi_pkg::USBI_ACT_FIRED;  // R16
          end
        end
        usbi_pkg::USBI_ACT_FIRED: begin
          if (idle_pulse) begin
            act_reg <= usbi_pkg::USBI_ACT_ARMED;  // R17
          end
        end
      endcase
    end
  end

  // error summary follows the enabled error sources only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_sum_reg <= 1'b0;
    end else begin
      err_sum_reg <= |(err_flags & err_enables);  // R10 R22
    end
  end

  // flag update: software write first, then hardware sets on top
  logic [6:0] hw_set;
  logic [6:0] wmask;

  // engine events count only while the block is operational
  always_comb begin
    hw_set                 = 7'h00;
    hw_set[`USBI_BIT_SOF]   = sof_evt && operational;        // R25
    hw_set[`USBI_BIT_STALL] = stall_evt && operational;      // R5
    hw_set[`USBI_BIT_IDLE]  = idle_pulse;                    // R6
    hw_set[`USBI_BIT_TRN]   = trn_evt && operational;        // R7
    hw_set[`USBI_BIT_ACT]   = act_fire;                      // R9
    hw_set[`USBI_BIT_RST]   = bus_reset_evt && operational;  // R12
  end

  // writable bits; the activity bit may not be cleared while unsettled
  always_comb begin
    wmask = `USBI_FLAGS_WMASK;                               // R11
    if (act_clear_blocked && flags_reg[`USBI_BIT_ACT]) begin
      wmask[`USBI_BIT_ACT] = 1'b0;                           // R13
    end
  end

  // written value replaces writable bits: zero clears, one sets
  always_comb begin
    flags_next = merge(flags_reg, wr_flags, wb_dat_i[6:0],
                       wmask, hw_set);                       // R2 R3 R20
    flags_next[`USBI_BIT_ERR] = err_sum_reg;                 // R11
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= 7'h00;                                    // R4
    end else begin
      flags_reg <= flags_next;
    end
  end

  // enables written in full; they never touch the flags
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enables_reg <= 7'h00;                                  // R21
    end else if (wr_enables) begin
      enables_reg <= wb_dat_i[6:0];
    end
  end

  // side effects of flag changes toward the engine

  // a software clear of the done flag steps the transfer status fifo on token transfers;
  // a set arriving in the same cycle keeps the flag and the entry
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_fifo_advance <= 1'b0;
    end else begin
      stat_fifo_advance <= flags_reg[`USBI_BIT_TRN]
                           && !flags_next[`USBI_BIT_TRN]
                           && trn_is_token;                  // R8
    end
  end

  // device address is reloaded with zero on every valid bus reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_addr_clear <= 1'b0;
    end else begin
      dev_addr_clear <= hw_set[`USBI_BIT_RST];               // R12
    end
  end

  // single combined request; enables gate only this path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_request <= 1'b0;
    end else begin
      peripheral_irq_request <= |(flags_next & enables_reg); // R1 R19 R23
    end
  end

  // read data; unused bits and unmapped offsets read zero
  logic [31:0] rd_word;

  always_comb begin
    rd_word = `USBI_RESET_WORD;
    unique case (sel)
      usbi_pkg::USBI_SEL_FLAGS:   rd_word[6:0] = flags_reg;    // R4
      usbi_pkg::USBI_SEL_ENABLES: rd_word[6:0] = enables_reg;  // R21
      usbi_pkg::USBI_SEL_CTRL: begin
        rd_word[`USBI_CTRL_SUSPEND] = suspend_request;
        rd_word[`USBI_CTRL_PLL_SEL] = pll_sel_reg;
        rd_word[`USBI_CTRL_READY]   = module_ready;
        rd_word[`USBI_CTRL_ARMED]   =
          (act_reg == usbi_pkg::USBI_ACT_ARMED);
      end
      usbi_pkg::USBI_SEL_NONE:    rd_word = `USBI_RESET_WORD;
    endcase
  end

  // read data is captured together with ack and held until next access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= `USBI_RESET_WORD;
    end else if (access) begin
      wb_dat_o <= wb_we_i ? `USBI_RESET_WORD : rd_word;
    end
  end

endmodule

`default_nettype wire

// ==== verif/usbi_host_model.sv ====
// upstream host line model: drives d+/d- toward the status block
// assumes one clock; traffic high means packets are on the wire
`timescale 1ns/1ps
`default_nettype none

module usbi_host_model (
  // clock
  input  wire logic clk,
  // request for bus traffic
  input  wire logic traffic,
  // bus lines
  output var  logic usb_dp,
  output var  logic usb_dm
);
  logic phase_reg;

  // alternate k and j each cycle while traffic runs
  always_ff @(posedge clk) begin
    phase_reg <= traffic ? ~phase_reg : 1'b0;
  end

  // released lines fall to the pulled idle state, never the last value
  assign usb_dp = traffic ? phase_reg : 1'b1;
  assign usb_dm = traffic ? ~phase_reg : 1'b0;
endmodule

`default_nettype wire

// ==== verif/usbi_top_assertions.sv ====
// port checker of the usb status interrupt block
// assumes a classic wishbone master that holds requests until ack
`timescale 1ns/1ps
`default_nettype none

module usbi_top_assertions (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // register bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o,
  // engine side
  input  wire logic        bus_reset_evt,
  input  wire logic        trn_is_token,
  input  wire logic        suspend_request,
  input  wire logic        module_ready,
  input  wire logic        stat_fifo_advance,
  input  wire logic        dev_addr_clear
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_ack_latency;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_latency: assert property (p_ack_latency)
    else $error("ack missing one cycle after request");

  property p_flags_upper;
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[31:7] == '0;
  endproperty
  a_flags_upper: assert property (p_flags_upper)
    else $error("flag read has upper bits set");

  property p_enables_upper;
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h4 |-> wb_dat_o[31:7] == '0;
  endproperty
  a_enables_upper: assert property (p_enables_upper)
    else $error("enable read has upper bits set");

  property p_unmapped;
    wb_ack_o && wb_adr_i == 4'hc |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access returned data");

  property p_addr_clear;
    bus_reset_evt && module_ready && !suspend_request |=> dev_addr_clear;
  endproperty
  a_addr_clear: assert property (p_addr_clear)
    else $error("bus reset did not clear address");

  property p_clear_cause;
    dev_addr_clear |-> $past(bus_reset_evt);
  endproperty
  a_clear_cause: assert property (p_clear_cause)
    else $error("address cleared without bus reset");

  // advance only from a recent write while a token entry is current
  property p_advance;
    stat_fifo_advance |-> ($past(trn_is_token) &&
      ($past(wb_we_i && wb_cyc_i) || $past(wb_we_i && wb_cyc_i, 2)))
      ##1 !stat_fifo_advance;
  endproperty
  a_advance: assert property (p_advance)
    else $error("fifo advance without token clear");

  property p_suspend;
    suspend_request [*2] |-> !module_ready;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("module ready while suspended");
endmodule

bind usbi_top usbi_top_assertions chk_u (.core_clk, .nrst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .bus_reset_evt,
  .trn_is_token, .suspend_request, .module_ready, .stat_fifo_advance,
  .dev_addr_clear);

`default_nettype wire

// ==== verif/usbi_top_tb.sv ====
// bench of the usb status interrupt block: registers, events, errors,
// idle and activity, suspend and pll wait
// assumes the design, host model and checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) chk(n, 32'(e), 32'(a))

module usbi_top_tb;
  typedef struct packed {
    logic [3:0] a;
    logic       s;
    logic [7:0] d;
    logic [7:0] e;
  } usbi_row_type;
  logic         core_clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0]   wb_adr_i, wb_sel_i, ev, hv;
  logic [31:0]  wb_dat_i, wb_dat_o, q;
  logic [7:0]   err_f, err_e;
  logic         tok, tr, pll_lock, usb_dp, usb_dm, irq, susp, rdy, adv, dac;
  int           n_fail, n_tests, n_adv, n_dac, i, k;
  int unsigned  pos [4] = '{6, 5, 3, 0};
  // write then read back each row; sel low and unmapped rows change nothing
  usbi_row_type rows [7] = '{'{4'h0, 1'b1, 8'h00, 8'h00},
    '{4'h4, 1'b1, 8'hff, 8'h7f}, '{4'h4, 1'b1, 8'h00, 8'h00},
    '{4'h0, 1'b1, 8'hff, 8'h7d}, '{4'h0, 1'b1, 8'h00, 8'h00},
    '{4'h0, 1'b0, 8'h7f, 8'h00}, '{4'hc, 1'b1, 8'hff, 8'h00}};

  usbi_top #(.IDLE_CYCLES(50), .IDLE_CNT_W(17), .WAKE_SYNC(4)) dut_u (
    .core_clk, .nrst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sof_evt(ev[3]), .stall_evt(ev[2]),
    .trn_evt(ev[1]), .bus_reset_evt(ev[0]), .trn_is_token(tok),
    .err_flags(err_f), .err_enables(err_e), .usb_dp, .usb_dm,
    .pll_locked(pll_lock), .peripheral_irq_request(irq),
    .suspend_request(susp), .module_ready(rdy), .stat_fifo_advance(adv),
    .dev_addr_clear(dac));
  usbi_host_model host_u (.clk(core_clk), .traffic(tr), .usb_dp, .usb_dm);

  // count output pulses; both are one cycle wide
  always @(posedge core_clk) begin
    if (adv === 1'b1) n_adv++;
    if (dac === 1'b1) n_dac++;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] a);
    n_tests++;
    if (a !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", n, e, a);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one classic cycle; hv rides along as engine events at the taking edge
  task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d,
                    input logic s);
    int t;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= {3'h0, s};
    wb_dat_i <= {24'h0, d};
    ev <= hv;
    t = 0;
    // ack is read as it stood at the rising edge; data is taken there too
    do begin
      @(posedge core_clk);
      ev <= 4'h0;
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      end_sim;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge core_clk);
    ev <= v;
    @(posedge core_clk);
    ev <= 4'h0;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // main sequence
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, tok, tr, pll_lock} = '0;
    {wb_adr_i, wb_sel_i, ev, hv, wb_dat_i, err_f, err_e} = '0;
    {n_fail, n_tests, n_adv, n_dac} = '0;
    repeat (3) @(posedge core_clk);
    `CHK("irq in reset", 1'b0, irq);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("flags at reset", 8'h00, q);
    wb(4'h4, 1'b0, 8'h00, 1'b1);
    `CHK("enables at reset", 8'h00, q);
    tr <= 1'b1;
    repeat (6) @(posedge core_clk);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("activity", 8'h04, q);
    for (i = 0; i < 7; i++) begin
      wb(rows[i].a, 1'b1, rows[i].d, rows[i].s);
      wb(rows[i].a, 1'b0, 8'h00, 1'b1);
      `CHK("row read", rows[i].e, q);
    end
    // each engine event alone, masked, enabled, then only others enabled
    for (k = 0; k < 4; k++) begin
      wb(4'h4, 1'b1, 8'h00, 1'b1);
      wb(4'h0, 1'b1, 8'h00, 1'b1);
      pulse(4'h8 >> k);
      wb(4'h0, 1'b0, 8'h00, 1'b1);
      `CHK("event flag", 8'h01 << pos[k], q);
      `CHK("irq masked", 1'b0, irq);
      wb(4'h4, 1'b1, 8'h01 << pos[k], 1'b1);
      @(negedge core_clk);  // request follows a new enable an edge later
      `CHK("irq enabled", 1'b1, irq);
      wb(4'h4, 1'b1, 8'h7f ^ (8'h01 << pos[k]), 1'b1);
      @(negedge core_clk);
      `CHK("irq others", 1'b0, irq);
    end
    `CHK("address clears", 1, n_dac);
    `CHK("advances", 0, n_adv);
    // clear racing a new completion, then a real clear
    tok <= 1'b1;
    pulse(4'h2);
    hv = 4'h2;
    wb(4'h0, 1'b1, 8'h00, 1'b1);
    hv = 4'h0;
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("set beats clear", 8'h08, q);
    `CHK("no advance", 0, n_adv);
    wb(4'h0, 1'b1, 8'h00, 1'b1);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("advance", 1, n_adv);
    // error summary follows enabled error flags only
    err_f <= 8'h01;
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("masked error", 8'h00, q);
    err_e <= 8'h01;
    repeat (2) @(posedge core_clk);
    wb(4'h0, 1'b1, 8'h00, 1'b1);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("error summary", 8'h02, q);
    err_f <= 8'h00;
    tr <= 1'b0;
    repeat (40) @(posedge core_clk);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("idle early", 8'h00, q);
    repeat (20) @(posedge core_clk);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("idle", 8'h10, q);
    wb(4'h8, 1'b0, 8'h00, 1'b1);
    `CHK("rearmed", 8'h0c, q);
    wb(4'h4, 1'b1, 8'h04, 1'b1);
    tr <= 1'b1;
    repeat (6) @(posedge core_clk);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("activity again", 8'h14, q);
    `CHK("activity irq", 1'b1, irq);
    wb(4'h0, 1'b1, 8'h00, 1'b1);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("once per resume", 8'h00, q);
    `CHK("irq after clear", 1'b0, irq);
    // wake from suspend: clear ignored, then firmware loop
    tr <= 1'b0;
    repeat (60) @(posedge core_clk);
    wb(4'h8, 1'b1, 8'h01, 1'b1);
    `CHK("suspend", 1'b1, susp);
    tr <= 1'b1;
    repeat (6) @(posedge core_clk);
    wb(4'h0, 1'b1, 8'h00, 1'b1);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("clear while suspended", 8'h04, q);
    wb(4'h8, 1'b1, 8'h00, 1'b1);
    // a clear three edges after wake-up falls inside the settle time
    wb(4'h0, 1'b1, 8'h00, 1'b1);
    wb(4'h0, 1'b0, 8'h00, 1'b1);
    `CHK("clear just after wake", 8'h04, q);
    for (i = 0; i < 10; i++) begin
      wb(4'h0, 1'b0, 8'h00, 1'b1);
      if (q[2] !== 1'b1) break;
      wb(4'h0, 1'b1, 8'h00, 1'b1);
    end
    `CHK("activity cleared", 1'b0, q[2]);
    // pll clock selected: wait for lock
    wb(4'h8, 1'b1, 8'h02, 1'b1);
    repeat (4) @(posedge core_clk);
    `CHK("ready before lock", 1'b0, rdy);
    pll_lock <= 1'b1;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) @(negedge core_clk);
    `CHK("ready after lock", 1'b1, rdy);
    end_sim;
  end
endmodule

`default_nettype wire
